// ### sbc_top.sv
// Baud generator, clock selection and init sequencing with AXI4-Lite registers
//
// Chosen here: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module sbc_top #(
  parameter int ADDR_W = 8 // Register address width
) (
  input wire logic aclk,                      // System clock
  input wire logic aresetn,                   // Sync reset, low
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid,             // Write address valid
  output logic s_axi_awready,                 // Write address ready
  input wire logic [31:0] s_axi_wdata,        // Write data
  input wire logic [3:0] s_axi_wstrb,         // Write byte strobes
  input wire logic s_axi_wvalid,              // Write data valid
  output logic s_axi_wready,                  // Write data ready
  output logic [1:0] s_axi_bresp,             // Write response
  output logic s_axi_bvalid,                  // Write response valid
  input wire logic s_axi_bready,              // Write response ready
  input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid,             // Read address valid
  output logic s_axi_arready,                 // Read address ready
  output logic [31:0] s_axi_rdata,            // Read data
  output logic [1:0] s_axi_rresp,             // Read response
  output logic s_axi_rvalid,                  // Read data valid
  input wire logic s_axi_rready,              // Read data ready
  input wire logic rxd_pin,                   // Serial data in
  input wire logic ext_rx_clock_pin,          // External receive clock
  input wire logic ext_tx_clock_pin_i,        // Transmit clock pin in
  output logic ext_tx_clock_pin_o,            // Transmit clock pin out
  output logic ext_tx_clock_pin_oe,           // Transmit clock pin drive
  input wire logic rx_char_valid,             // Received character strobe
  input wire logic [7:0] rx_char,             // Received character
  input wire logic rx_ninth,                  // Received ninth bit
  input wire logic rx_break,                  // Line break received
  output logic core_enable,                   // Tx and rx enabled
  output logic tx_bit_tick,                   // Transmit bit clock pulse
  output logic rx_bit_sample,                 // Receive sample pulse
  output logic rxd_synced,                    // Synchronised rx data
  output logic addr_hit                       // Address interrupt pulse
);
  // Decode of mapped register offsets
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    is_mapped = (a == ADDR_W'(sbc_pkg::ADDR_DIV_LO)) || (a == ADDR_W'(sbc_pkg::ADDR_DIV_HI)) ||
                (a == ADDR_W'(sbc_pkg::ADDR_CHCFG)) || (a == ADDR_W'(sbc_pkg::ADDR_CMP)) ||
                (a == ADDR_W'(sbc_pkg::ADDR_STATUS));
  endfunction : is_mapped

  // Write channel holding state
  logic aw_held_r, aw_held_nxt; // Address captured
  logic w_held_r, w_held_nxt;   // Data captured
  logic [ADDR_W-1:0] aw_addr_r; // Captured address
  logic [31:0] w_data_r;        // Captured data
  logic w_lane0_r;              // Low byte strobe
  logic aw_take, w_take, do_write; // Handshake terms
  logic ar_take; // Read accepted
  logic [31:0] rd_word; // Read mux

  // Software state
  logic [7:0] div_lo_r; // Divisor low byte
  logic [7:0] div_hi_r; // Divisor high byte
  sbc_pkg::sbc_cfg_t cfg_r; // Channel configuration
  logic [7:0] cmp_r; // Address compare value
  logic enable_r; // Circuitry enabled
  logic load_r; // Divisor load pulse
  logic hit_sticky_r, hit_sticky_nxt; // Address hit status

  // Write decodes
  logic wr_lo, wr_hi, wr_cfg, wr_cmp, wr_status;

  // Address trigger
  sbc_pkg::sbc_amode_t amode; // Effective trigger
  logic after_break_r; // Break seen before char
  logic char_eq; // Compare equal
  logic hit_cond; // Trigger met
  logic hit_event; // Qualified hit

  // Clock selection
  logic rxc_s1_r, rxc_s2_r, rxc_s3_r; // Rx clock sync
  logic txc_s1_r, txc_s2_r, txc_s3_r; // Tx clock sync
  logic rxc_edge, txc_edge; // Rising edges
  logic brg_src; // Generator input event
  logic brg_clk, brg_tick, brg_running; // Generator outputs
  logic tx_src; // Transmit clock event
  logic [3:0] tx16_r; // Transmit divide by sixteen
  logic tx_tick_c; // Transmit bit event
  logic clk_pin_c, oe_c; // Pin next values

  // Handshake terms
  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take = s_axi_wvalid & s_axi_wready;
  assign do_write = aw_held_r & w_held_r & ~s_axi_bvalid;
  assign aw_held_nxt = (aw_held_r | aw_take) & ~do_write;
  assign w_held_nxt = (w_held_r | w_take) & ~do_write;
  assign ar_take = s_axi_arvalid & s_axi_arready;

  // Address and data capture, either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      aw_held_r <= aw_held_nxt;
      w_held_r <= w_held_nxt;
      s_axi_awready <= ~aw_held_nxt;
      s_axi_wready <= ~w_held_nxt;
    end
  end

  // Payload registers, no reset needed
  always_ff @(posedge aclk) begin
    if (aw_take) begin
      aw_addr_r <= s_axi_awaddr;
    end
    if (w_take) begin
      w_data_r <= s_axi_wdata;
      w_lane0_r <= s_axi_wstrb[0];
    end
  end

  // Write response after both halves
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= sbc_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= is_mapped(aw_addr_r) ? sbc_pkg::RESP_OKAY : sbc_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Register write decodes
  assign wr_lo = do_write & w_lane0_r & (aw_addr_r == ADDR_W'(sbc_pkg::ADDR_DIV_LO));
  assign wr_hi = do_write & w_lane0_r & (aw_addr_r == ADDR_W'(sbc_pkg::ADDR_DIV_HI));
  assign wr_cfg = do_write & w_lane0_r & (aw_addr_r == ADDR_W'(sbc_pkg::ADDR_CHCFG));
  assign wr_cmp = do_write & w_lane0_r & (aw_addr_r == ADDR_W'(sbc_pkg::ADDR_CMP));
  assign wr_status = do_write & w_lane0_r & (aw_addr_r == ADDR_W'(sbc_pkg::ADDR_STATUS));

  // Configuration and compare registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_lo_r <= sbc_pkg::DIV_BYTE_RST;
      div_hi_r <= sbc_pkg::DIV_BYTE_RST;
      cfg_r <= sbc_pkg::CFG_RST;
      cmp_r <= sbc_pkg::CMP_RST;
    end else begin
      if (wr_lo) div_lo_r <= w_data_r[7:0];
      if (wr_hi) div_hi_r <= w_data_r[7:0];
      if (wr_cfg) cfg_r <= w_data_r[6:0];
      if (wr_cmp) cmp_r <= w_data_r[7:0];
    end
  end

  // Enable sequencing on divisor writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable_r <= 1'b0;
      load_r <= 1'b0;
    end else begin
      if (wr_hi) begin
        enable_r <= 1'b0;
      end else if (wr_lo) begin
        enable_r <= 1'b1;
      end
      load_r <= wr_lo;
    end
  end

  assign amode = cfg_r.sync_mode ? sbc_pkg::AMODE_MATCH :
    sbc_pkg::sbc_amode_t'({cfg_r.address_mode_enable, cfg_r.address_mode_sel});
  assign char_eq = (rx_char == cmp_r);
  assign hit_cond = (amode == sbc_pkg::AMODE_NINTH) ? rx_ninth :
                    (amode == sbc_pkg::AMODE_MATCH) ? char_eq :
                    (amode == sbc_pkg::AMODE_MATCH_NINTH) ? (char_eq & rx_ninth) :
                    (char_eq & after_break_r);
  assign hit_event = enable_r & rx_char_valid & hit_cond;
  // Hit is set-wins over software clear
  assign hit_sticky_nxt = hit_event | (hit_sticky_r & ~(wr_status & w_data_r[sbc_pkg::ST_ADDR_HIT]));

  // Break memory and hit status
  always_ff @(posedge aclk) begin
    if (!aresetn || !enable_r) begin
      after_break_r <= 1'b0;
      hit_sticky_r <= 1'b0;
      addr_hit <= 1'b0;
    end else begin
      after_break_r <= rx_break | (after_break_r & ~rx_char_valid);
      hit_sticky_r <= hit_sticky_nxt;
      addr_hit <= hit_event;
    end
  end

  // Read mux
  assign rd_word =
    (s_axi_araddr == ADDR_W'(sbc_pkg::ADDR_DIV_LO)) ? {24'h000000, div_lo_r} :
    (s_axi_araddr == ADDR_W'(sbc_pkg::ADDR_DIV_HI)) ? {24'h000000, div_hi_r} :
    (s_axi_araddr == ADDR_W'(sbc_pkg::ADDR_CHCFG)) ? {25'h0, cfg_r} :
    (s_axi_araddr == ADDR_W'(sbc_pkg::ADDR_CMP)) ? {24'h000000, cmp_r} :
    (s_axi_araddr == ADDR_W'(sbc_pkg::ADDR_STATUS)) ?
      {29'h0, hit_sticky_r, brg_running, enable_r} : 32'h00000000;

  // Read channel, answer one cycle after acceptance
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= sbc_pkg::RESP_OKAY;
    end else if (ar_take) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= is_mapped(s_axi_araddr) ? sbc_pkg::RESP_OKAY : sbc_pkg::RESP_SLVERR;
    end else if (!s_axi_rvalid || s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {rxc_s1_r, rxc_s2_r, rxc_s3_r} <= 3'h0;
      {txc_s1_r, txc_s2_r, txc_s3_r} <= 3'h0;
    end else begin
      {rxc_s1_r, rxc_s2_r, rxc_s3_r} <= {ext_rx_clock_pin, rxc_s1_r, rxc_s2_r};
      {txc_s1_r, txc_s2_r, txc_s3_r} <= {ext_tx_clock_pin_i, txc_s1_r, txc_s2_r};
    end
  end
  assign rxc_edge = rxc_s2_r & ~rxc_s3_r;
  assign txc_edge = txc_s2_r & ~txc_s3_r;

  assign brg_src = cfg_r.ext_rx_clock_enable ? rxc_edge : 1'b1;

  sbc_baud_gen #(.DIV_W(sbc_pkg::DIV_W)) u_brg (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(enable_r),
    .load(load_r),
    .divisor({div_hi_r, div_lo_r}),
    .src_tick(brg_src),
    .clk_out(brg_clk),
    .tick(brg_tick),
    .running(brg_running)
  );

  // tx clock from pin or generator
  assign tx_src = cfg_r.tx_clock_src_sel ? txc_edge : brg_tick;
  assign tx_tick_c = tx_src & (cfg_r.clock_divide_sel | (tx16_r == sbc_pkg::SUB_LAST));

  // Transmit divide-by-sixteen
  always_ff @(posedge aclk) begin
    if (!aresetn || !enable_r) begin
      tx16_r <= 4'h0;
      tx_bit_tick <= 1'b0;
    end else begin
      if (tx_src) tx16_r <= tx16_r + 1'b1;
      tx_bit_tick <= tx_tick_c;
    end
  end

  assign oe_c = enable_r & ~cfg_r.tx_clock_src_sel;
  assign clk_pin_c = cfg_r.clock_out_src_sel ?
    (cfg_r.clock_divide_sel ? brg_clk : tx16_r[3]) : brg_clk;

  // Transmit clock pin drive
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_tx_clock_pin_o <= 1'b0;
      ext_tx_clock_pin_oe <= 1'b0;
      core_enable <= 1'b0;
    end else begin
      ext_tx_clock_pin_o <= oe_c & clk_pin_c;
      ext_tx_clock_pin_oe <= oe_c;
      core_enable <= enable_r;
    end
  end

  // Receive sampling on generator ticks
  sbc_rx_timing u_rx (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(enable_r),
    .x16_mode(~cfg_r.clock_divide_sel),
    .tick(brg_tick),
    .rxd_pin(rxd_pin),
    .rxd_sync(rxd_synced),
    .sample(rx_bit_sample)
  );

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_hi_write_off: assert property (wr_hi |=> (!enable_r ##1 !core_enable))
    else $error("high byte write did not disable");
  a_lo_write_on: assert property (wr_lo |=> (enable_r && load_r))
    else $error("low byte write did not restart");
  a_sync_match_only: assert property ((hit_event && cfg_r.sync_mode) |-> char_eq)
    else $error("non-match trigger in sync mode");
  a_ninth_trigger: assert property ((enable_r && rx_char_valid && rx_ninth && !cfg_r.sync_mode &&
    !cfg_r.address_mode_enable && !cfg_r.address_mode_sel) |=> addr_hit)
    else $error("ninth bit trigger missed");
  a_div16_ticks: assert property ((tx_tick_c && !cfg_r.clock_divide_sel) |-> (tx16_r == 4'hf))
    else $error("bit tick not every sixteenth");
  a_pin_dir: assert property ((wr_cfg && w_data_r[1]) |=> ##1 !ext_tx_clock_pin_oe)
    else $error("pin driven while external tx clock");
  a_write_resp: assert property (do_write |=> s_axi_bvalid)
    else $error("write not answered");
  c_addr_hit: cover property (addr_hit);
  c_restart: cover property (wr_hi ##[1:50] wr_lo);
endmodule : sbc_top
`default_nettype wire

// ### sbc_pkg.sv
// Shared constants and types of the serial baud and clock block
package sbc_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_DIV_LO = 8'h00;
  localparam logic [7:0] ADDR_DIV_HI = 8'h04;
  localparam logic [7:0] ADDR_CHCFG = 8'h08;
  localparam logic [7:0] ADDR_CMP = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Divider limits and oversampling
  localparam int DIV_W = 16;
  localparam logic [15:0] DIV_MIN = 16'h0002;
  localparam logic [3:0] SUB_LAST = 4'hf;
  localparam logic [3:0] SUB_MID = 4'h7;
  // Status bit positions
  localparam int ST_ENABLED = 0;
  localparam int ST_RUNNING = 1;
  localparam int ST_ADDR_HIT = 2;
  // Reset values
  localparam logic [7:0] DIV_BYTE_RST = 8'h00;
  localparam logic [7:0] CMP_RST = 8'h00;
  // Channel configuration fields, bit 0 last
  typedef struct packed {
    logic address_mode_sel;    // Bit 6
    logic address_mode_enable; // Bit 5
    logic sync_mode;           // Bit 4
    logic ext_rx_clock_enable; // Bit 3
    logic clock_out_src_sel;   // Bit 2
    logic tx_clock_src_sel;    // Bit 1
    logic clock_divide_sel;    // Bit 0
  } sbc_cfg_t;
  localparam sbc_cfg_t CFG_RST = 7'h00;
  // Address interrupt triggers
  typedef enum logic [1:0] {
    AMODE_NINTH,
    AMODE_MATCH,
    AMODE_MATCH_NINTH,
    AMODE_MATCH_BREAK
  } sbc_amode_t;
endpackage : sbc_pkg

// ### sbc_baud_gen.sv
// Programmable divide-by-N baud generator
`timescale 1ns/10ps
`default_nettype none
module sbc_baud_gen #(
  parameter int DIV_W = 16
) (
  input wire logic aclk,               // System clock
  input wire logic aresetn,            // Sync reset, low
  input wire logic run,                // Generator enabled
  input wire logic load,               // Load divisor now
  input wire logic [DIV_W-1:0] divisor, // Divide ratio
  input wire logic src_tick,           // Input clock event
  output logic clk_out,                // Divided clock level
  output logic tick,                   // End of period pulse
  output logic running                 // Divider active
);
  logic [DIV_W-1:0] count_r; // Down counter
  logic [DIV_W-1:0] count_nxt;
  logic stop; // Divider halted
  logic [DIV_W-1:0] half; // High phase threshold

  assign stop = ~run | (divisor < DIV_W'(sbc_pkg::DIV_MIN));
  assign half = divisor >> 1;
  assign count_nxt = load ? divisor - 1'b1 :
                     (~src_tick) ? count_r :
                     (count_r == '0) ? divisor - 1'b1 : count_r - 1'b1;

  // Counter and outputs
  always_ff @(posedge aclk) begin
    if (!aresetn || stop) begin
      count_r <= '0;
      clk_out <= 1'b0;
      tick <= 1'b0;
    end else begin
      count_r <= count_nxt;
      clk_out <= (count_nxt >= half);
      tick <= ~load & src_tick & (count_r == '0);
    end
  end

  // Activity flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      running <= 1'b0;
    end else begin
      running <= ~stop;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_low_div_stop: assert property (stop |=> (!tick && !clk_out))
    else $error("divider ran with divisor below two");
  a_load_immediate: assert property ((load && !stop) |=> (count_r == $past(divisor) - 1'b1))
    else $error("divisor not loaded at once");
  a_tick_at_zero: assert property (tick |-> ($past(count_r) == '0 && $past(src_tick)))
    else $error("tick away from terminal count");
  c_tick_seen: cover property (tick ##[1:40] tick);
endmodule : sbc_baud_gen
`default_nettype wire

// ### sbc_rx_timing.sv
// Receive data synchroniser and bit sampling point
`timescale 1ns/10ps
`default_nettype none
module sbc_rx_timing (
  input wire logic aclk,     // System clock
  input wire logic aresetn,  // Sync reset, low
  input wire logic run,      // Receiver enabled
  input wire logic x16_mode, // Sixteen ticks per bit
  input wire logic tick,     // Receive clock event
  input wire logic rxd_pin,  // Serial data in
  output logic rxd_sync,     // Synchronised data
  output logic sample        // Bit sample pulse
);
  logic s1_r; // First synchroniser stage
  logic s3_r; // Edge history
  logic [3:0] sub_r; // Sub-bit counter
  logic fall; // Start edge seen

  assign fall = ~rxd_sync & s3_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_r <= 1'b1;
      rxd_sync <= 1'b1;
      s3_r <= 1'b1;
    end else begin
      s1_r <= rxd_pin;
      rxd_sync <= s1_r;
      s3_r <= rxd_sync;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !run || fall) begin
      sub_r <= '0;
    end else if (tick) begin
      sub_r <= sub_r + 1'b1;
    end
  end

  // Sample mid bit or every tick
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sample <= 1'b0;
    end else begin
      sample <= run & tick & ~fall & (~x16_mode | (sub_r == sbc_pkg::SUB_MID));
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_mid_sample: assert property ((sample && $past(x16_mode)) |-> ($past(sub_r) == 4'h7))
    else $error("sample not at bit middle");
  a_rx_sync_delay: assert property (($past(aresetn) && $past(aresetn, 2)) |-> (rxd_sync == $past(rxd_pin, 2)))
    else $error("data sync latency wrong");
  c_mid_sample: cover property (fall ##[1:200] sample);
endmodule : sbc_rx_timing
`default_nettype wire

// ### sbc_remote.sv
// Remote serial device model: link clock and long low frames
`timescale 1ns/10ps
`default_nettype none
module sbc_remote (
  input wire logic aclk,    // System clock
  input wire logic aresetn, // Sync reset, low
  input wire logic clk_run, // Link clock wanted
  input wire logic send,    // Start a low frame
  output logic link_clk,    // Remote serial clock
  output logic rxd          // Remote serial data
);
  logic [1:0] ph_r; // Half period count
  logic [7:0] low_r; // Low cycles left
  // period eight cycles, well inside limit
  always_ff @(posedge aclk) begin
    ph_r <= (clk_run && aresetn) ? ph_r + 2'h1 : 2'h0;
    if (!clk_run || !aresetn) begin
      link_clk <= 1'b0; // Stands still while clk_run is low
    end else if (ph_r == 2'h3) begin
      link_clk <= ~link_clk;
    end
  end
  // data moves on the clock grid, no skew
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_r <= 8'h00; // No frame pending
      rxd <= 1'b1; // Idle line is high
    end else begin
      low_r <= send ? 8'hc8 : ((low_r != 8'h00) ? low_r - 8'h01 : 8'h00);
      rxd <= (low_r == 8'h00) && !send; // Idle line is high
    end
  end
endmodule : sbc_remote
`default_nettype wire

// ### testbench.sv
// Self-checking bench of the baud and clock block
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic aclk, aresetn, awv, wv, bre, arv, rre, run_c, send, cv, nin, brk; // Inputs
  logic [7:0] awa, ara, ch; // Addresses, received char
  logic [31:0] wd, rd; // Write and read data
  logic awr, wr, bv, arr, rv, lclk, rxd, to_o, to_oe, en, txt, rxs, rsync, hit; // Outputs
  logic [1:0] br, rr; // Responses
  int fail_count, checked, hits, g, k; // Counters
  logic [7:0] cfgs [5] = '{8'h01, 8'h41, 8'h21, 8'h61, 8'h11}; // Trigger modes
  int exps [5] = '{2, 3, 1, 1, 3}; // Expected hits per mode
  sbc_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre), .rxd_pin(rxd),
    .ext_rx_clock_pin(lclk), .ext_tx_clock_pin_i(lclk), .ext_tx_clock_pin_o(to_o),
    .ext_tx_clock_pin_oe(to_oe), .rx_char_valid(cv), .rx_char(ch), .rx_ninth(nin),
    .rx_break(brk), .core_enable(en), .tx_bit_tick(txt), .rx_bit_sample(rxs),
    .rxd_synced(rsync), .addr_hit(hit));
  sbc_remote u_rem (.aclk(aclk), .aresetn(aresetn), .clk_run(run_c), .send(send),
    .link_clk(lclk), .rxd(rxd));
  // Free running system clock
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  // Address interrupt pulse count
  always @(posedge aclk) begin
    if (hit === 1'b1) hits++;
  end
  // Compare and report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Bus write, both channels offered together
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    bit ta, tw;
    ta = 0;
    tw = 0;
    @(posedge aclk);
    awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; bre <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge aclk);
      if (!ta && awr === 1'b1) begin ta = 1; awv <= 1'b0; end
      if (!tw && wr === 1'b1) begin tw = 1; wv <= 1'b0; end
    end
    while (bv !== 1'b1) @(posedge aclk);
    bre <= 1'b0;
    chk(br, sbc_pkg::RESP_OKAY);
  endtask : axw
  // Bus read with expected data and response
  task automatic axr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    @(posedge aclk);
    ara <= a; arv <= 1'b1; rre <= 1'b1;
    do @(posedge aclk); while (arr !== 1'b1);
    arv <= 1'b0;
    while (rv !== 1'b1) @(posedge aclk);
    rre <= 1'b0;
    chk(rd, e);
    chk(rr, r);
  endtask : axr
  task automatic init(input logic [15:0] n, input logic [7:0] c);
    axw(sbc_pkg::ADDR_DIV_HI, {24'h0, n[15:8]});
    @(posedge aclk);
    chk(en, 1'b0);
    axw(sbc_pkg::ADDR_CHCFG, {24'h0, c});
    axw(sbc_pkg::ADDR_CMP, 32'h5a);
    axw(sbc_pkg::ADDR_DIV_LO, {24'h0, n[7:0]});
    repeat (3) @(posedge aclk);
  endtask : init
  // Pick an output to time
  function automatic logic pick(input int s);
    return (s == 0) ? txt : ((s == 1) ? rxs : to_o);
  endfunction : pick
  // Cycles between two pulses
  task automatic gap(input int s, input int e);
    do @(posedge aclk); while (pick(s) !== 1'b1);
    g = 0;
    do begin @(posedge aclk); g++; end while (pick(s) !== 1'b1);
    chk(g, e);
  endtask : gap
  // Cycles with an output high in a span
  task automatic cnt(input int s, input int span, input int e);
    g = 0;
    repeat (span) begin @(posedge aclk); if (pick(s) === 1'b1) g++; end
    chk(g, e);
  endtask : cnt
  // One received character, break first if asked
  task automatic rxc(input logic [7:0] c, input logic n, input logic b);
    @(posedge aclk); brk <= b;
    @(posedge aclk); brk <= 1'b0; ch <= c; nin <= n; cv <= 1'b1;
    @(posedge aclk); cv <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask : rxc
  // Verdict and end of run
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_sim
  // Watchdog
  initial begin
    #2000000;
    fail_count++;
    end_sim();
  end
  // Main sequence
  initial begin
    {aresetn, awv, wv, bre, arv, rre, run_c, send, cv, nin, brk} = '0;
    {awa, ara, ch, wd, fail_count, checked} = '0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    chk({en, rsync}, 2'b01);
    axr(sbc_pkg::ADDR_STATUS, 32'h0, sbc_pkg::RESP_OKAY);
    axr(8'h14, 32'h0, sbc_pkg::RESP_SLVERR);
    for (k = 4; k < 6; k++) begin
      init(16'(k), 8'h01);
      chk({en, to_oe}, 2'b11);
      gap(0, k);
      cnt(2, 4 * k, 4 * ((k + 1) / 2));
    end
    init(16'h0004, 8'h00);
    gap(0, 64);
    init(16'h0002, 8'h04);
    cnt(2, 64, 32);
    init(16'h0001, 8'h01);
    cnt(0, 40, 0);
    axr(sbc_pkg::ADDR_STATUS, 32'h1, sbc_pkg::RESP_OKAY);
    axw(sbc_pkg::ADDR_DIV_LO, 32'h4);
    gap(0, 4);
    axw(sbc_pkg::ADDR_DIV_HI, 32'h0);
    cnt(0, 40, 0);
    axr(sbc_pkg::ADDR_STATUS, 32'h0, sbc_pkg::RESP_OKAY);
    run_c <= 1'b1;
    init(16'h0002, 8'h09);
    gap(0, 16);
    init(16'h0002, 8'h03);
    gap(0, 8);
    chk(to_oe, 1'b0);
    init(16'h0002, 8'h00);
    send <= 1'b1;
    @(posedge aclk) send <= 1'b0;
    gap(1, 32);
    for (k = 0; k < 5; k++) begin
      init(16'h0004, cfgs[k]);
      g = hits;
      rxc(8'h5a, 1'b0, 1'b0);
      rxc(8'h33, 1'b1, 1'b0);
      rxc(8'h5a, 1'b1, 1'b0);
      rxc(8'h5a, 1'b0, 1'b1);
      chk(hits - g, exps[k]);
    end
    axr(sbc_pkg::ADDR_STATUS, 32'h7, sbc_pkg::RESP_OKAY);
    axw(sbc_pkg::ADDR_STATUS, 32'h4);
    axr(sbc_pkg::ADDR_STATUS, 32'h3, sbc_pkg::RESP_OKAY);
    end_sim();
  end
endmodule : testbench
`default_nettype wire
